//--- rtl/vdwc_ctrl.sv
// Host controller that drives the video DRAM random port through its pins.
`timescale 1ns/1ps

// Contract
// [R1] Selects and data at edges pick function.
// [R2] Low selects at row edge: per-bit mask.
// [R3] Special select at column: block or color.
// [R4] Masked block uses both masks.
// [R5] Pause then eight row cycles wake-up.
// [R6] Early write keeps outputs off.
// [R7] Late write: output enable holds buffers off.
// [R8] Read-write delays met gives read data.
// [R9] Otherwise outputs undefined until column rises.
// [R10] Data taken at later strobe edge.
// [R11] Outputs release on enable or column rise.
// [R12] Outputs off while column strobe high.
// [R13] Column low at row fall keeps data.
// [R14] Address changes limited per strobe phase.
// [R15] Enable high during late write.
// [R16] Writes and reads mix in page mode; here each access runs its own full row strobe cycle.
// [R17] Column-first sequence triggers internal refresh.
// [R18] Refresh all 512 rows each period.
// [R19] Mask select: masked at row, read/write.
// [R20] Row, column, then both strobes high.
module vdwc_ctrl #(
  parameter int PAUSE_CYC   = vdwc_pkg::PAUSE_CYC,   // Power-up pause.
  parameter int REF_INT_CYC = vdwc_pkg::REF_INT_CYC  // Refresh spacing.
) (
  input  wire logic                    core_clk_i,  // Core clock.
  input  wire logic                    reset_i,     // Asynchronous reset.
  input  wire logic                    req_valid_i, // Request offered.
  input  wire vdwc_pkg::vdwc_req_t     req_i,       // Request contents.
  output logic                         req_ready_o, // Request taken.
  output logic                         rd_valid_o,  // Read data pulse.
  output logic [vdwc_pkg::DW-1:0]      rd_data_o,   // Read data.
  output logic                         init_done_o, // Wake-up finished.
  output vdwc_pkg::vdwc_pins_t         pins_o,      // Strobes and address.
  output logic [vdwc_pkg::DW-1:0]      dq_o,        // Data pin output.
  output logic                         dq_oe_n_o,   // Low while driving.
  input  wire logic [vdwc_pkg::DW-1:0] dq_i         // Data pin input.
);

  // Sequencer states.
  typedef enum logic [3:0] {
    S_PAUSE, S_WAKE_LO, S_WAKE_HI, S_IDLE, S_ROW, S_COL, S_WE,
    S_CHI, S_PRE, S_CBR_C, S_CBR_R
  } vdwc_st_t;

  localparam int CW = 24;  // Width of the long counter.

  vdwc_st_t               st_r, st_nxt;          // State.
  logic [vdwc_pkg::TW-1:0] t_r, t_nxt;           // Phase timer.
  logic [CW-1:0]          ref_r, ref_nxt;        // Refresh interval timer.
  logic                   ref_due_r, ref_due_nxt;// Refresh owed.
  logic [3:0]             wake_r, wake_nxt;      // Wake-up cycles done.
  vdwc_pkg::vdwc_req_t    q_r, q_nxt;            // Request in service.
  vdwc_pkg::vdwc_pins_t   p_r, p_nxt;            // Pin levels.
  logic [vdwc_pkg::DW-1:0] dq_r, dq_nxt;         // Data pin level.
  logic                   dqoe_r, dqoe_nxt;      // Data enable, low drives.
  logic                   rdy_r, rdy_nxt;        // Ready pulse.
  logic                   rv_r, rv_nxt;          // Read valid pulse.
  logic [vdwc_pkg::DW-1:0] rd_r, rd_nxt;         // Read data.
  logic                   done_r, done_nxt;      // Wake-up complete.
  logic                   wr_op, sfs_col, rmw_op;// Decoded request.

  // Decode whether the op writes, and the special select at column edge.
  always_comb begin
    wr_op   = (q_r.op != vdwc_pkg::VDWC_READ);
    rmw_op  = (q_r.op == vdwc_pkg::VDWC_RMW);
    sfs_col = (q_r.op == vdwc_pkg::VDWC_BLOCK_WRITE) ||
              (q_r.op == vdwc_pkg::VDWC_MBLOCK_WRITE) ||
              (q_r.op == vdwc_pkg::VDWC_LOAD_COLOR);  // R3 R4
  end

  // Next-state logic for the whole pin sequencer.
  always_comb begin
    st_nxt      = st_r;
    t_nxt       = (t_r != '0) ? t_r - 1'b1 : t_r;
    ref_nxt     = ref_r;
    ref_due_nxt = ref_due_r;
    wake_nxt    = wake_r;
    q_nxt       = q_r;
    p_nxt       = p_r;
    dq_nxt      = dq_r;
    dqoe_nxt    = dqoe_r;
    rdy_nxt     = 1'b0;
    rv_nxt      = 1'b0;
    rd_nxt      = rd_r;
    done_nxt    = done_r;
    // Refresh spacing keeps all rows refreshed each period.
    if (ref_r == CW'(REF_INT_CYC - 1)) begin
      ref_nxt     = '0;
      ref_due_nxt = 1'b1;                          // R18
    end else begin
      ref_nxt = ref_r + 1'b1;
    end
    case (st_r)
      S_PAUSE: begin
        ref_nxt = '0;
        // Power-up pause counted in the long counter.
        if (ref_r == CW'(PAUSE_CYC - 1)) begin
          st_nxt = S_WAKE_LO;                      // R5
          t_nxt  = 8'(vdwc_pkg::C_RAS);
        end else begin
          ref_nxt = ref_r + 1'b1;
        end
      end
      S_WAKE_LO: begin
        p_nxt.ras_n = 1'b0;
        if (t_r == '0) begin
          p_nxt.ras_n = 1'b1;
          wake_nxt    = wake_r + 1'b1;
          st_nxt      = S_WAKE_HI;
          t_nxt       = 8'(vdwc_pkg::C_RP);
        end
      end
      S_WAKE_HI: begin
        // Eight row-only cycles before first access.
        if (t_r == '0) begin
          if (wake_r == 4'(vdwc_pkg::WAKE_CYCLES)) begin
            st_nxt      = S_IDLE;                  // R5
            done_nxt    = 1'b1;
            ref_due_nxt = 1'b0;
          end else begin
            st_nxt = S_WAKE_LO;
            t_nxt  = 8'(vdwc_pkg::C_RAS);
          end
        end
      end
      S_IDLE: begin
        if (ref_due_r) begin
          // Column strobe first starts an internal refresh.
          // A new interval ending in this same cycle must not be lost.
          ref_due_nxt = (ref_r == CW'(REF_INT_CYC - 1));
          p_nxt.cas_n = 1'b0;                      // R17
          p_nxt.mws_n = 1'b1;
          p_nxt.sfs   = 1'b1;
          st_nxt      = S_CBR_C;
          t_nxt       = 8'(vdwc_pkg::C_CP);
        end else if (req_valid_i) begin
          rdy_nxt = 1'b1;
          q_nxt   = req_i;
          st_nxt  = S_ROW;
          t_nxt   = 8'(vdwc_pkg::C_RCD);
          // Row edge: address, mask select, special select, mask data.
          p_nxt.addr  = req_i.row;                 // R20 R14
          p_nxt.ras_n = 1'b0;
          p_nxt.mws_n = !((req_i.op == vdwc_pkg::VDWC_MASK_WRITE) ||
                          (req_i.op == vdwc_pkg::VDWC_MBLOCK_WRITE)); // R19
          p_nxt.sfs   = (req_i.op == vdwc_pkg::VDWC_LOAD_COLOR);  // R1
          p_nxt.oe_n  = 1'b1;
          dq_nxt      = req_i.mask;                // R2 R4
          dqoe_nxt    = !((req_i.op == vdwc_pkg::VDWC_MASK_WRITE) ||
                          (req_i.op == vdwc_pkg::VDWC_MBLOCK_WRITE));
        end
      end
      S_ROW: begin
        if (t_r == '0) begin
          // Column edge; early write lowers write enable in the same cycle.
          p_nxt.addr  = q_r.col;                   // R14 R20
          p_nxt.cas_n = 1'b0;
          p_nxt.sfs   = sfs_col;                   // R3 R4
          p_nxt.mws_n = !(wr_op && !rmw_op);       // R6 R19
          // Read-modify-write opens the outputs for its read phase.
          p_nxt.oe_n  = wr_op && !rmw_op;          // R15
          dq_nxt      = q_r.data;                  // R10
          dqoe_nxt    = !(wr_op && !rmw_op);
          st_nxt      = rmw_op ? S_WE : S_COL;
          t_nxt       = rmw_op ? 8'(vdwc_pkg::C_CWD) :
                                 8'(vdwc_pkg::C_CAS);
        end
      end
      S_WE: begin
        // Read-write: sample data, lift enable, then late write.
        if (t_r == 8'(vdwc_pkg::C_OD)) begin
          rd_nxt     = dq_i;                       // R8
          rv_nxt     = 1'b1;
          p_nxt.oe_n = 1'b1;                       // R7 R9 R15
        end
        if (t_r == '0) begin
          p_nxt.mws_n = 1'b0;                      // R10
          dqoe_nxt    = 1'b0;
          st_nxt      = S_COL;
          t_nxt       = 8'(vdwc_pkg::C_CAS);
        end
      end
      S_COL: begin
        if (t_r == '0) begin
          if (!wr_op) begin
            rd_nxt = dq_i;                         // R11
            rv_nxt = 1'b1;
          end
          p_nxt.cas_n = 1'b1;                      // R12 R13
          p_nxt.oe_n  = 1'b1;
          st_nxt      = S_CHI;
          t_nxt       = 8'(vdwc_pkg::C_CP);
        end
      end
      S_CHI: begin
        if (t_r == '0) begin
          p_nxt.ras_n = 1'b1;                      // R20
          p_nxt.mws_n = 1'b1;
          dqoe_nxt    = 1'b1;
          st_nxt      = S_PRE;
          t_nxt       = 8'(vdwc_pkg::C_RP);
        end
      end
      S_CBR_C: begin
        if (t_r == '0) begin
          p_nxt.ras_n = 1'b0;                      // R17
          st_nxt      = S_CBR_R;
          t_nxt       = 8'(vdwc_pkg::C_RAS);
        end
      end
      S_CBR_R: begin
        if (t_r == '0) begin
          p_nxt.ras_n = 1'b1;
          p_nxt.cas_n = 1'b1;
          st_nxt      = S_PRE;
          t_nxt       = 8'(vdwc_pkg::C_RP);
        end
      end
      S_PRE: begin
        if (t_r == '0) begin
          st_nxt = S_IDLE;                         // R16
        end
      end
      default: begin
        st_nxt = S_IDLE;
      end
    endcase
  end

  // Registers of the sequencer.
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_r      <= S_PAUSE;
      t_r       <= '0;
      ref_r     <= '0;
      ref_due_r <= 1'b0;
      wake_r    <= '0;
      q_r       <= '0;
      p_r       <= '{ras_n: 1'b1, cas_n: 1'b1, mws_n: 1'b1, sfs: 1'b0,
                     oe_n: 1'b1, addr: '0};
      dq_r      <= '0;
      dqoe_r    <= 1'b1;
      rdy_r     <= 1'b0;
      rv_r      <= 1'b0;
      rd_r      <= '0;
      done_r    <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      t_r       <= t_nxt;
      ref_r     <= ref_nxt;
      ref_due_r <= ref_due_nxt;
      wake_r    <= wake_nxt;
      q_r       <= q_nxt;
      p_r       <= p_nxt;
      dq_r      <= dq_nxt;
      dqoe_r    <= dqoe_nxt;
      rdy_r     <= rdy_nxt;
      rv_r      <= rv_nxt;
      rd_r      <= rd_nxt;
      done_r    <= done_nxt;
    end
  end

  // Outputs come straight from the registers.
  assign pins_o      = p_r;
  assign dq_o        = dq_r;
  assign dq_oe_n_o   = dqoe_r;
  assign req_ready_o = rdy_r;
  assign rd_valid_o  = rv_r;
  assign rd_data_o   = rd_r;
  assign init_done_o = done_r;

  // The host never drives data while output enable is low.
  property p_no_contention;
    @(posedge core_clk_i) disable iff (reset_i)
      !p_r.oe_n |-> dqoe_r;
  endproperty
  a_no_contention: assert property (p_no_contention) // R7
    else $error("Data driven while outputs enabled.");

  // Column strobe only falls while the row strobe is low or for refresh.
  property p_row_first;
    @(posedge core_clk_i) disable iff (reset_i)
      $fell(p_r.cas_n) |-> !p_r.ras_n || st_r == S_CBR_C;
  endproperty
  a_row_first: assert property (p_row_first) // R20
    else $error("Column strobe fell before row strobe.");

  // Refresh column strobe precedes the row strobe.
  property p_cbr;
    @(posedge core_clk_i) disable iff (reset_i)
      $rose(st_r == S_CBR_C) |-> !p_r.cas_n && p_r.ras_n;
  endproperty
  a_cbr: assert property (p_cbr) // R17
    else $error("Refresh not column first.");

  // Address stays put while the column strobe is low.
  property p_addr;
    @(posedge core_clk_i) disable iff (reset_i)
      !p_r.cas_n && !$past(p_r.cas_n) |-> $stable(p_r.addr);
  endproperty
  a_addr: assert property (p_addr) // R14
    else $error("Address changed with column strobe low.");

  // Output enable stays high whenever write enable and column strobe are low.
  property p_oe_write;
    @(posedge core_clk_i) disable iff (reset_i)
      !p_r.mws_n && !p_r.cas_n |-> p_r.oe_n;
  endproperty
  a_oe_write: assert property (p_oe_write) // R15
    else $error("Output enable low during write.");

  // No access before wake-up ends.
  property p_wake;
    @(posedge core_clk_i) disable iff (reset_i)
      req_ready_o |-> init_done_o;
  endproperty
  a_wake: assert property (p_wake) // R5
    else $error("Access before wake-up done.");

  // The row strobe falls, with the column strobe high, in the same cycle as the ready pulse.
  property p_row_fall;
    @(posedge core_clk_i) disable iff (reset_i)
      rdy_nxt |=> !p_r.ras_n && p_r.cas_n;
  endproperty
  a_row_fall: assert property (p_row_fall) // R13
    else $error("Row strobe did not fall with column high.");

  // A refresh is issued within a short bound once owed in idle.
  property p_ref;
    @(posedge core_clk_i) disable iff (reset_i)
      st_r == S_IDLE && ref_due_r |=> st_r == S_CBR_C;
  endproperty
  a_ref: assert property (p_ref) // R18
    else $error("Owed refresh not started.");

endmodule : vdwc_ctrl

//--- common/vdwc_pkg.sv
// Package of constants and carrier types for the video DRAM write controller.
package vdwc_pkg;

  // Clock period in nanoseconds (100 MHz core clock).
  localparam int CLK_NS = 10;

  // Pin timing figures in nanoseconds, as the strobes need them.
  localparam int T_RCD_NS  = 20;   // Row strobe to column strobe delay.
  localparam int T_CAS_NS  = 20;   // Column strobe pulse width.
  localparam int T_RP_NS   = 50;   // Row strobe precharge.
  localparam int T_CP_NS   = 10;   // Column precharge time.
  localparam int T_CWD_NS  = 40;   // Column strobe to write enable delay.
  localparam int T_OD_NS   = 10;   // Output disable delay from enable.
  localparam int T_RAS_NS  = 70;   // Row strobe pulse width.

  // Least times round up to whole cycles, never below one.
  function automatic int cyc_min(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_min

  localparam int C_RCD = cyc_min(T_RCD_NS);
  localparam int C_CAS = cyc_min(T_CAS_NS);
  localparam int C_RP  = cyc_min(T_RP_NS);
  localparam int C_CP  = cyc_min(T_CP_NS);
  localparam int C_CWD = cyc_min(T_CWD_NS);
  localparam int C_OD  = cyc_min(T_OD_NS);
  localparam int C_RAS = cyc_min(T_RAS_NS);

  // Wake-up pause and refresh figures.
  localparam int T_PAUSE_US   = 100;     // Initial pause after power-up.
  localparam int T_REF_US     = 16700;   // Refresh period, 16.7 ms.
  localparam int ROWS         = 512;     // Rows covered per period.
  localparam int WAKE_CYCLES  = 8;       // Row strobe cycles of wake-up.
  localparam int PAUSE_CYC    = T_PAUSE_US * 1000 / CLK_NS;
  localparam int REF_INT_CYC  = T_REF_US * 1000 / CLK_NS / ROWS;

  // Widths of the pins and of a timing counter.
  localparam int AW = 9;
  localparam int DW = 8;
  localparam int TW = 8;   // Width of a timing counter.

  // Write function requested by the user side.
  typedef enum logic [2:0] {
    VDWC_READ,          // Plain read.
    VDWC_WRITE,         // Normal write.
    VDWC_MASK_WRITE,    // Per-bit masked write.
    VDWC_BLOCK_WRITE,   // Block write, column mask only.
    VDWC_MBLOCK_WRITE,  // Block write with bit-plane mask.
    VDWC_LOAD_COLOR,    // Load the color register.
    VDWC_RMW            // Read then late write.
  } vdwc_op_t;

  // One access request from the user side.
  typedef struct packed {
    vdwc_op_t          op;     // Function to perform.
    logic [AW-1:0]     row;    // Row address.
    logic [AW-1:0]     col;    // Column address.
    logic [DW-1:0]     mask;   // Bit-plane mask for masked functions.
    logic [DW-1:0]     data;   // Write data, column mask or color.
  } vdwc_req_t;

  // Levels driven onto the memory pins.
  typedef struct packed {
    logic              ras_n;  // Row strobe.
    logic              cas_n;  // Column strobe.
    logic              mws_n;  // Mask/write select.
    logic              sfs;    // Special function select.
    logic              oe_n;   // Transfer/output enable.
    logic [AW-1:0]     addr;   // Multiplexed address.
  } vdwc_pins_t;

endpackage : vdwc_pkg

//--- sim/vdwc_mem_model.sv
// Behavioural model of the video DRAM random port.
`timescale 1ns/1ps
module vdwc_mem_model #(
  parameter int PAUSE_CYC   = 20,
  parameter int REF_INT_CYC = 200
) (
  input  wire logic                 core_clk_i,
  input  wire logic                 reset_i,
  input  wire vdwc_pkg::vdwc_pins_t pins_i,
  input  wire logic [7:0]           dq_i,
  input  wire logic                 dq_oe_n_i,
  output logic [7:0]                dq_o,
  output logic                      drive_o,
  output int                        viol_o
);
  vdwc_pkg::vdwc_pins_t p;  // Pin levels seen at the previous edge.
  logic [7:0] mem [logic [17:0]];
  logic [7:0] color, rmask, rdat, last;
  logic [8:0] row, col;
  logic       rsel, rsfs, rdc, wdone;
  int         pause, wake, gap, nras, ncas;

  initial viol_o = 0;

  function automatic logic [7:0] rd(input logic [17:0] a);
    return mem.exists(a) ? mem[a] : 8'h00;
  endfunction : rd

  // Performs the write function picked at the two strobe edges.
  task automatic wr(input logic s, input logic [7:0] d);
    logic [7:0]  pm;
    logic [17:0] a;
    pm = rsel ? 8'hFF : rmask;
    if (rsfs && s) color = d;
    else if (rsfs) viol_o++;
    else if (!s) begin
      a = {row, col};
      mem[a] = (rd(a) & ~pm) | (d & pm);
    end else begin
      for (int i = 0; i < 8; i++) begin
        a = {row, col[8:3], 3'(i)};
        if (d[i]) mem[a] = (rd(a) & ~pm) | (color & pm);
      end
    end
  endtask : wr

  // Read data stands only while both strobes and output enable are low.
  assign drive_o = rdc && !pins_i.ras_n && !pins_i.cas_n && !pins_i.oe_n;
  // A released bus shows the inverse of the last value, not a hold.
  assign dq_o = drive_o ? rdat : ~last;

  // Edge decoding and the checks that bind the controller side.
  always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      p = '1;
      p.sfs = 1'b0;
      {pause, wake, gap, nras, ncas} = '0;
      {rdc, wdone, last} = {2'b01, 8'h00};
    end else begin
      if (pause < PAUSE_CYC) pause++;
      if (wake == 8) gap++;
      if (gap > REF_INT_CYC + 40) viol_o++;
      if (p.ras_n && !pins_i.ras_n) begin
        if (wake == 0 && pause < PAUSE_CYC - 1) viol_o++;
        if (wake < 8) wake++;
        if (!pins_i.cas_n) gap = 0;
        {nras, ncas} = '0;
        {row, rsel, rsfs, rmask} = {pins_i.addr, pins_i.mws_n, pins_i.sfs, dq_i};
      end
      if (!p.ras_n && !pins_i.ras_n && p.addr != pins_i.addr) begin
        nras++;
        if (p.cas_n && pins_i.cas_n) ncas++;
        if (nras > 2 || ncas > 1) viol_o++;
      end
      if (p.cas_n && !pins_i.cas_n && !pins_i.ras_n) begin
        if (wake < 8) viol_o++;
        {col, rdc, wdone} = {pins_i.addr, pins_i.mws_n, 1'b0};
        rdat = rd({row, pins_i.addr});
      end
      if (!pins_i.ras_n && !pins_i.cas_n && !pins_i.mws_n && !wdone) begin
        if (rdc && !pins_i.oe_n) viol_o++;
        if (dq_oe_n_i) viol_o++;
        wr(pins_i.sfs, dq_i);
        wdone = 1'b1;
      end
      if (!p.cas_n && pins_i.cas_n) {rdc, wdone, ncas} = {2'b01, 32'd0};
      if (drive_o && !dq_oe_n_i) viol_o++;
      if (drive_o) last = rdat;
      p = pins_i;
    end
  end
endmodule : vdwc_mem_model

//--- sim/test_video_dram_port_write_cycle_control.sv
// Self-checking bench for the video DRAM write controller.
`timescale 1ns/1ps
module test_video_dram_port_write_cycle_control;
  localparam int PAUSE = 20;
  localparam int REFI  = 200;
  logic                 core_clk, reset, req_valid, req_ready;
  logic                 rd_valid, init_done, dq_oe_n, drive;
  vdwc_pkg::vdwc_req_t  req;
  vdwc_pkg::vdwc_pins_t pins;
  logic [7:0]           rd_data, host_dq, mem_dq, dq_bus, color_s;
  int                   viol, error_cnt, cmp_count;
  logic [7:0]           shadow [logic [17:0]];

  // The data bus carries whichever side has its buffers on.
  assign dq_bus = !dq_oe_n ? host_dq : mem_dq;

  vdwc_ctrl #(.PAUSE_CYC(PAUSE), .REF_INT_CYC(REFI)) dut (
    .core_clk_i(core_clk), .reset_i(reset), .req_valid_i(req_valid),
    .req_i(req), .req_ready_o(req_ready), .rd_valid_o(rd_valid),
    .rd_data_o(rd_data), .init_done_o(init_done), .pins_o(pins),
    .dq_o(host_dq), .dq_oe_n_o(dq_oe_n), .dq_i(dq_bus));

  vdwc_mem_model #(.PAUSE_CYC(PAUSE), .REF_INT_CYC(REFI)) mem (
    .core_clk_i(core_clk), .reset_i(reset), .pins_i(pins), .dq_i(host_dq),
    .dq_oe_n_i(dq_oe_n), .dq_o(mem_dq), .drive_o(drive), .viol_o(viol));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    cmp_count++;
    if (seen !== want) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out

  function automatic logic [7:0] sh(input logic [17:0] a);
    return shadow.exists(a) ? shadow[a] : 8'h00;
  endfunction : sh

  // New cell content after a write function with mask m and value v.
  function automatic logic [7:0] new_word(input vdwc_pkg::vdwc_op_t op,
      input logic [7:0] old, input logic [7:0] m, input logic [7:0] v);
    if (op == vdwc_pkg::VDWC_MASK_WRITE || op == vdwc_pkg::VDWC_MBLOCK_WRITE)
      return (old & ~m) | (v & m);
    return (op == vdwc_pkg::VDWC_READ) ? old : v;
  endfunction : new_word

  // Offers one request, holds it until taken, and fetches read data.
  task automatic access(input vdwc_pkg::vdwc_op_t op, input logic [8:0] r,
      input logic [8:0] c, input logic [7:0] m, input logic [7:0] d,
      output logic [7:0] q);
    int n;
    n = 0;
    @(negedge core_clk);  // A lowered valid stands for one cycle first.
    req = '{op, r, c, m, d};
    req_valid = 1'b1;
    do begin @(negedge core_clk); n++; end
    while (req_ready !== 1'b1 && n < 400);
    check({7'h00, req_ready}, 8'h01);
    @(negedge core_clk);
    req_valid = 1'b0;
    if (op == vdwc_pkg::VDWC_READ || op == vdwc_pkg::VDWC_RMW) begin
      n = 0;
      while (rd_valid !== 1'b1 && n < 60) begin @(negedge core_clk); n++; end
      check({7'h00, rd_valid}, 8'h01);
    end
    q = rd_data;
  endtask : access

  // Runs one function, then reads back its cell, or for block writes a random cell of its eight-column block.
  task automatic op_chk(input vdwc_pkg::vdwc_op_t op, input logic [8:0] r,
      input logic [8:0] c, input logic [7:0] m, input logic [7:0] d);
    logic [7:0] q;
    logic [8:0] cc;
    logic       blk;
    access(op, r, c, m, d, q);
    if (op == vdwc_pkg::VDWC_READ || op == vdwc_pkg::VDWC_RMW)
      check(q, sh({r, c}));
    blk = op == vdwc_pkg::VDWC_BLOCK_WRITE || op == vdwc_pkg::VDWC_MBLOCK_WRITE;
    cc = blk ? {c[8:3], 3'($urandom_range(0, 7))} : c;
    if (op == vdwc_pkg::VDWC_LOAD_COLOR) color_s = d;
    else if (blk) begin
      for (int i = 0; i < 8; i++)
        if (d[i]) shadow[{r, c[8:3], 3'(i)}] =
          new_word(op, sh({r, c[8:3], 3'(i)}), m, color_s);
    end else shadow[{r, c}] = new_word(op, sh({r, c}), m, d);
    access(vdwc_pkg::VDWC_READ, r, cc, 8'h00, 8'h00, q);
    check(q, sh({r, cc}));
  endtask : op_chk

  task automatic wait_init();
    int n;
    n = 0;
    while (init_done !== 1'b1 && n < 600) begin @(negedge core_clk); n++; end
    check({7'h00, init_done}, 8'h01);
    check({7'h00, n >= PAUSE + 8}, 8'h01);
  endtask : wait_init

  initial begin
    reset     = 1'b1;
    req_valid = 1'b0;
    req       = '0;
    color_s   = 8'h00;
    error_cnt = 0;
    cmp_count = 0;
    void'($urandom(32'h664F));
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    check({pins.ras_n, pins.cas_n, pins.mws_n, pins.oe_n, dq_oe_n, init_done,
           rd_valid, req_ready}, 8'hF8);
    reset = 1'b0;
    wait_init();
    $display("test wake-up done");
    op_chk(vdwc_pkg::VDWC_LOAD_COLOR, 9'h003, 9'h008, 8'h00, 8'hA5);
    op_chk(vdwc_pkg::VDWC_BLOCK_WRITE, 9'h003, 9'h008, 8'h00, 8'h81);
    op_chk(vdwc_pkg::VDWC_MBLOCK_WRITE, 9'h003, 9'h00F, 8'h0F, 8'hFF);
    op_chk(vdwc_pkg::VDWC_MASK_WRITE, 9'h003, 9'h009, 8'h00, 8'hFF);
    op_chk(vdwc_pkg::VDWC_MASK_WRITE, 9'h003, 9'h009, 8'hFF, 8'h3C);
    op_chk(vdwc_pkg::VDWC_WRITE, 9'h1FF, 9'h1FF, 8'h00, 8'h5A);
    op_chk(vdwc_pkg::VDWC_RMW, 9'h1FF, 9'h1FF, 8'h00, 8'hC3);
    $display("test corners done");
    repeat (50) op_chk(vdwc_pkg::vdwc_op_t'($urandom_range(0, 6)),
      9'($urandom_range(0, 3)), 9'($urandom_range(0, 31)),
      8'($urandom), 8'($urandom));
    $display("test random done");
    repeat (3 * REFI) @(negedge core_clk);
    $display("test refresh done");
    reset = 1'b1;
    repeat (2) @(negedge core_clk);
    reset = 1'b0;
    wait_init();
    op_chk(vdwc_pkg::VDWC_READ, 9'h1FF, 9'h1FF, 8'h00, 8'h00);
    check({7'h00, viol != 0}, 8'h00);
    $display("test second reset done");
    close_out();
  end

  initial begin
    repeat (40000) @(posedge core_clk);
    error_cnt++;
    close_out();
  end
endmodule : test_video_dram_port_write_cycle_control
